/* File: dsw_defines.svh */
// constants for the deep-sleep watchdog and retention block
// assumes inclusion by dsw_top.sv only, not by dsw_pkg.sv
`ifndef DSW_DEFINES_SVH
`define DSW_DEFINES_SVH

// config_word_four field positions
`define DSW_CW4_EN_BIT      7
`define DSW_CW4_CLKSEL_BIT  5
`define DSW_CW4_PS_MSB      4
`define DSW_CW4_PS_LSB      0

// register bit positions
`define DSW_OSC_SECONDARY_OSC_ENABLE_BIT  1
`define DSW_RESET_CONTROL_REG_STATUS_BIT 10
`define DSW_RTC_POWER_CONTROL_REG_SEL_HI   11
`define DSW_RTC_POWER_CONTROL_REG_SEL_LO   10

// timeout range: ratio is 2**(ps + shift) source ticks
`define DSW_PS_SHIFT        5
`define DSW_MIN_TIMEOUT_MS  1
`define DSW_MAX_TIMEOUT_CD  2570

// reset values
`define DSW_SEM_RST         16'h0000
`define DSW_WAKE_RST        3'h0
`define DSW_SECONDARY_OSCILLATOR_EN_RST     1'b0

`endif

/* File: dsw_pkg.sv */
// types for the deep-sleep watchdog and retention block
// uses no macros, so it does not include dsw_defines.svh
package dsw_pkg;

  typedef enum logic [1:0] {
    DSW_ACTIVE = 2'b00,
    DSW_START  = 2'b01,
    DSW_SLEEP  = 2'b10
  } dsw_state_t;

  // watchdog configuration taken from config_word_four
  typedef struct packed {
    logic       en;
    logic       clk_sel;
    logic [4:0] ps;
  } dsw_cfg_t;

  // wake source record
  typedef struct packed {
    logic master_clear;
    logic wdt;
    logic ext;
  } dsw_wake_t;

  typedef enum logic [1:0] {
    DSW_RTC_SECONDARY_OSCILLATOR = 2'b00,
    DSW_RTC_LOW_POWER_RC_CLOCK = 2'b01,
    DSW_RTC_OFF0 = 2'b10,
    DSW_RTC_OFF1 = 2'b11
  } dsw_rtc_sel_t;

endpackage : dsw_pkg

/* File: dsw_top.sv */
// deep-sleep retention, i/o hold and deep-sleep watchdog
// assumes slow clocks and readiness arrive asynchronously on pins
//
// How it works
// - master clear in sleep keeps retained registers, hold
// - master clear in sleep keeps oscillator state
// - master clear in sleep resets the pins
// - oscillator enable writes ignored while hold set
// - watchdog runs only when enable bit set
// - watchdog independent of main watchdog enable
// - sleep entry clears counter and postscaler
// - one config bit selects watchdog clock
// - five config bits select postscaler ratio
// - timeout spans 1 ms to 25.7 days
// - rtc and watchdog each pick either clock
// - two rtc power bits select rtc clock
// - watchdog clock auto-started on sleep entry
// - counting waits until that clock is ready
// - entry sets status flag, software clears it
// - power-on reset clears all deep-sleep logic
`timescale 1ns/1ps
`include "dsw_defines.svh"

module dsw_top
  import dsw_pkg::*;
#(
  parameter int CNT_W = 37
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        master_clear_pin,
  input  wire logic        sleep_enter,
  input  wire logic        ext_wake_pin,
  input  wire logic [7:0]  config_word_four,
  input  wire logic [15:0] rtc_power_control_reg,
  input  wire logic        osc_wr,
  input  wire logic [15:0] osc_wdata,
  input  wire logic        hold_release,
  input  wire logic        status_clear,
  input  wire logic        sem_wr,
  input  wire logic        sem_sel,
  input  wire logic [15:0] sem_wdata,
  input  wire logic        secondary_oscillator_clk_pin,
  input  wire logic        low_power_rc_clock_clk_pin,
  input  wire logic        secondary_oscillator_ready_pin,
  input  wire logic        low_power_rc_clock_ready_pin,
  output logic             in_deep_sleep,
  output logic             io_hold,
  output logic             io_reset,
  output logic             wake_event,
  output logic             secondary_oscillator_run,
  output logic             low_power_rc_clock_run,
  output logic             rtc_tick,
  output logic [15:0]      oscillator_control_reg,
  output logic [15:0]      reset_control_reg,
  output logic [15:0]      deep_sleep_control_reg,
  output logic [2:0]       deep_sleep_wake_source_reg,
  output logic [31:0]      deep_sleep_semaphore_regs
);

  // ****************************************
  // elaboration checks
  // ****************************************
  localparam int PS_MAX_EXP = 31 + `DSW_PS_SHIFT;

  initial begin
    if (CNT_W < PS_MAX_EXP + 1) begin
      $error("dsw_top: CNT_W too small for longest postscale");
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam int NSYNC = 6;

  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic [NSYNC-1:0] sync3_r;
  logic [NSYNC-1:0] sync_in;

  assign sync_in = {ext_wake_pin, master_clear_pin, low_power_rc_clock_ready_pin,
                    secondary_oscillator_ready_pin, low_power_rc_clock_clk_pin, secondary_oscillator_clk_pin};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= sync_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  logic secondary_oscillator_tick;
  logic low_power_rc_clock_tick;
  logic secondary_oscillator_rdy;
  logic low_power_rc_clock_rdy;
  logic master_clear_pulse;
  logic ext_wake;

  // rising edges of slow clocks become one-cycle enables
  assign secondary_oscillator_tick  = sync2_r[0] & ~sync3_r[0];
  assign low_power_rc_clock_tick  = sync2_r[1] & ~sync3_r[1];
  assign secondary_oscillator_rdy   = sync2_r[2];
  assign low_power_rc_clock_rdy   = sync2_r[3];
  assign master_clear_pulse = sync2_r[4] & ~sync3_r[4];
  assign ext_wake   = sync2_r[5];

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [CNT_W-1:0] terminal_count(input logic [4:0] ps);
    logic [CNT_W-1:0] one;
    one = {{(CNT_W-1){1'b0}}, 1'b1};
    terminal_count = (one << (ps + 6'(`DSW_PS_SHIFT))) - one;
  endfunction : terminal_count

  function automatic logic pick_tick(input logic use_low_power_rc_clock, input logic s,
                                     input logic l);
    pick_tick = use_low_power_rc_clock ? l : s;
  endfunction : pick_tick

  // ****************************************
  // configuration decode
  // ****************************************
  dsw_cfg_t     cfg;
  dsw_rtc_sel_t rtc_sel;

  // main watchdog enable is not an input at all
  assign cfg.en      = config_word_four[`DSW_CW4_EN_BIT];
  assign cfg.clk_sel = config_word_four[`DSW_CW4_CLKSEL_BIT];
  assign cfg.ps      = config_word_four[`DSW_CW4_PS_MSB:`DSW_CW4_PS_LSB];
  assign rtc_sel     = dsw_rtc_sel_t'(
    rtc_power_control_reg[`DSW_RTC_POWER_CONTROL_REG_SEL_HI:`DSW_RTC_POWER_CONTROL_REG_SEL_LO]);

  // ****************************************
  // state registers
  // ****************************************
  dsw_state_t       state_r,  state_nxt;
  logic [CNT_W-1:0] cnt_r,    cnt_nxt;
  logic             hold_r,   hold_nxt;
  logic             secondary_oscillator_r,   secondary_oscillator_nxt;
  logic             stat_r,   stat_nxt;
  logic             iorst_r,  iorst_nxt;
  logic             wake_r,   wake_nxt;
  dsw_wake_t        src_r,    src_nxt;
  logic [15:0]      sem0_r,   sem0_nxt;
  logic [15:0]      sem1_r,   sem1_nxt;

  logic wdt_tick;
  logic wdt_rdy;
  logic sleeping;

  assign sleeping = (state_r != DSW_ACTIVE);
  assign wdt_tick = pick_tick(cfg.clk_sel, secondary_oscillator_tick, low_power_rc_clock_tick);
  assign wdt_rdy  = pick_tick(cfg.clk_sel, secondary_oscillator_rdy, low_power_rc_clock_rdy);

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    hold_nxt  = hold_r;
    secondary_oscillator_nxt  = secondary_oscillator_r;
    stat_nxt  = stat_r;
    iorst_nxt = 1'b0;
    wake_nxt  = 1'b0;
    src_nxt   = src_r;
    sem0_nxt  = sem0_r;
    sem1_nxt  = sem1_r;

    // semaphores written only while awake
    if (sem_wr && !sleeping) begin
      if (sem_sel) begin
        sem1_nxt = sem_wdata;
      end else begin
        sem0_nxt = sem_wdata;
      end
    end

    // oscillator enable frozen while pins are held
    if (osc_wr && !hold_r && !sleeping) begin
      secondary_oscillator_nxt = osc_wdata[`DSW_OSC_SECONDARY_OSC_ENABLE_BIT];
    end

    // firmware unlocks pins after wake-up
    if (hold_release && !sleeping) begin
      hold_nxt = 1'b0;
    end

    if (status_clear) begin
      stat_nxt = 1'b0;
    end

    case (state_r)
      DSW_ACTIVE: begin
        if (master_clear_pulse) begin
          // plain master clear outside sleep
          secondary_oscillator_nxt  = `DSW_SECONDARY_OSCILLATOR_EN_RST;
          hold_nxt  = 1'b0;
          src_nxt   = `DSW_WAKE_RST;
          iorst_nxt = 1'b1;
        end else if (sleep_enter) begin
          state_nxt = DSW_START;
          cnt_nxt   = '0;
          hold_nxt  = 1'b1;
          stat_nxt  = 1'b1;
          src_nxt   = `DSW_WAKE_RST;
        end
      end
      DSW_START: begin
        // wait for the selected clock before counting
        if (master_clear_pulse) begin
          state_nxt   = DSW_ACTIVE;
          src_nxt.master_clear = 1'b1;
          iorst_nxt   = 1'b1;
          wake_nxt    = 1'b1;
        end else if (ext_wake) begin
          state_nxt   = DSW_ACTIVE;
          src_nxt.ext = 1'b1;
          wake_nxt    = 1'b1;
        end else if (!cfg.en || wdt_rdy) begin
          state_nxt = DSW_SLEEP;
        end
      end
      DSW_SLEEP: begin
        if (master_clear_pulse) begin
          state_nxt    = DSW_ACTIVE;
          src_nxt.master_clear = 1'b1;
          iorst_nxt    = 1'b1;
          wake_nxt     = 1'b1;
        end else if (ext_wake) begin
          state_nxt   = DSW_ACTIVE;
          src_nxt.ext = 1'b1;
          wake_nxt    = 1'b1;
        end else if (cfg.en && wdt_tick) begin
          if (cnt_r >= terminal_count(cfg.ps)) begin
            state_nxt   = DSW_ACTIVE;
            src_nxt.wdt = 1'b1;
            wake_nxt    = 1'b1;
            cnt_nxt     = '0;
          end else begin
            cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
      end
      default: begin
        state_nxt = DSW_ACTIVE;
      end
    endcase

    // a clear never beats a fresh entry
    if (state_r == DSW_ACTIVE && state_nxt == DSW_START) begin
      stat_nxt = 1'b1;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // power-on reset clears retained state too
      state_r <= DSW_ACTIVE;
      cnt_r   <= '0;
      hold_r  <= 1'b0;
      secondary_oscillator_r  <= `DSW_SECONDARY_OSCILLATOR_EN_RST;
      stat_r  <= 1'b0;
      iorst_r <= 1'b0;
      wake_r  <= 1'b0;
      src_r   <= `DSW_WAKE_RST;
      sem0_r  <= `DSW_SEM_RST;
      sem1_r  <= `DSW_SEM_RST;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      hold_r  <= hold_nxt;
      secondary_oscillator_r  <= secondary_oscillator_nxt;
      stat_r  <= stat_nxt;
      iorst_r <= iorst_nxt;
      wake_r  <= wake_nxt;
      src_r   <= src_nxt;
      sem0_r  <= sem0_nxt;
      sem1_r  <= sem1_nxt;
    end
  end

  // ****************************************
  // clock requests and outputs
  // ****************************************
  logic wdt_needs_clk;
  logic rtc_tick_r;

  assign wdt_needs_clk = sleeping && cfg.en;

  // each consumer turns on only the source it uses
  always_comb begin
    secondary_oscillator_run = secondary_oscillator_r | (wdt_needs_clk & ~cfg.clk_sel) | (rtc_sel == DSW_RTC_SECONDARY_OSCILLATOR);
    low_power_rc_clock_run = (wdt_needs_clk & cfg.clk_sel) | (rtc_sel == DSW_RTC_LOW_POWER_RC_CLOCK);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rtc_tick_r <= 1'b0;
    end else begin
      rtc_tick_r <= (rtc_sel == DSW_RTC_SECONDARY_OSCILLATOR) ? secondary_oscillator_tick :
                    (rtc_sel == DSW_RTC_LOW_POWER_RC_CLOCK) ? low_power_rc_clock_tick : 1'b0;
    end
  end

  always_comb begin
    oscillator_control_reg = 16'h0000;
    oscillator_control_reg[`DSW_OSC_SECONDARY_OSC_ENABLE_BIT] = secondary_oscillator_r;
    reset_control_reg = 16'h0000;
    reset_control_reg[`DSW_RESET_CONTROL_REG_STATUS_BIT] = stat_r;
    deep_sleep_control_reg = {14'h0000, sleeping, hold_r};
  end

  assign in_deep_sleep              = sleeping;
  assign io_hold                    = hold_r;
  assign io_reset                   = iorst_r;
  assign wake_event                 = wake_r;
  assign rtc_tick                   = rtc_tick_r;
  assign deep_sleep_wake_source_reg = src_r;
  assign deep_sleep_semaphore_regs  = {sem1_r, sem0_r};

endmodule : dsw_top

/* File: dsw_monitor.sv */
// checker for dsw_top port relations
// assumes it is bound to dsw_top by the statement at the foot
`timescale 1ns/1ps

module dsw_monitor
  import dsw_pkg::*;
#(
  parameter int CNT_W = 37
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        sleep_enter,
  input wire logic        osc_wr,
  input wire logic        sem_wr,
  input wire logic        hold_release,
  input wire logic        status_clear,
  input wire logic [7:0]  config_word_four,
  input wire logic [15:0] rtc_power_control_reg,
  input wire logic        in_deep_sleep,
  input wire logic        io_hold,
  input wire logic        io_reset,
  input wire logic        wake_event,
  input wire logic        secondary_oscillator_run,
  input wire logic        low_power_rc_clock_run,
  input wire logic [15:0] oscillator_control_reg,
  input wire logic [15:0] reset_control_reg,
  input wire logic [2:0]  deep_sleep_wake_source_reg,
  input wire logic [31:0] deep_sleep_semaphore_regs
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ****************
  // entry, wake and retention
  // ****************
  property p_entry;
    $rose(in_deep_sleep) |-> $past(sleep_enter) && io_hold && reset_control_reg[10];
  endproperty
  a_entry: assert property (p_entry) else $error("entry without hold");
  property p_hold_osc;
    io_hold && osc_wr |=> $stable(oscillator_control_reg);
  endproperty
  a_hold_osc: assert property (p_hold_osc) else $error("osc write under hold");
  property p_master_clear_wake;
    io_reset && wake_event |-> deep_sleep_wake_source_reg[2] && io_hold && !in_deep_sleep;
  endproperty
  a_master_clear_wake: assert property (p_master_clear_wake) else $error("master_clear wake state");
  property p_master_clear_keep;
    io_reset && wake_event && !$past(osc_wr) && !$past(sem_wr)
      |-> $stable(oscillator_control_reg) && $stable(deep_sleep_semaphore_regs);
  endproperty
  a_master_clear_keep: assert property (p_master_clear_keep) else $error("master_clear lost state");
  property p_wdt_wake;
    wake_event && deep_sleep_wake_source_reg[1]
      |-> $past(config_word_four[7]) && io_hold && !in_deep_sleep;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake state");
  property p_clk_req;
    in_deep_sleep && config_word_four[7]
      |-> (config_word_four[5] ? low_power_rc_clock_run : secondary_oscillator_run);
  endproperty
  a_clk_req: assert property (p_clk_req) else $error("watchdog clock off");
  property p_rtc_src;
    (rtc_power_control_reg[11:10] != 2'h0 || secondary_oscillator_run)
      && (rtc_power_control_reg[11:10] != 2'h1 || low_power_rc_clock_run);
  endproperty
  a_rtc_src: assert property (p_rtc_src) else $error("rtc clock off");
  property p_status;
    $fell(reset_control_reg[10]) |-> $past(status_clear) || $past(sys_rst);
  endproperty
  a_status: assert property (p_status) else $error("status lost");
  property p_hold_rel;
    $fell(io_hold) |-> ($past(hold_release) && !$past(in_deep_sleep)) || $past(sys_rst)
      || io_reset;
  endproperty
  a_hold_rel: assert property (p_hold_rel) else $error("hold dropped");
  c_wdt: cover property (wake_event && deep_sleep_wake_source_reg[1]);
  c_master_clear: cover property (io_reset && wake_event);
  c_ext: cover property (wake_event && deep_sleep_wake_source_reg[0]);
endmodule : dsw_monitor

bind dsw_top dsw_monitor #(.CNT_W(CNT_W)) u_mon (
  .clk(clk), .sys_rst(sys_rst), .sleep_enter(sleep_enter), .osc_wr(osc_wr),
  .sem_wr(sem_wr), .hold_release(hold_release), .status_clear(status_clear),
  .config_word_four(config_word_four), .rtc_power_control_reg(rtc_power_control_reg),
  .in_deep_sleep(in_deep_sleep), .io_hold(io_hold), .io_reset(io_reset),
  .wake_event(wake_event), .secondary_oscillator_run(secondary_oscillator_run), .low_power_rc_clock_run(low_power_rc_clock_run),
  .oscillator_control_reg(oscillator_control_reg), .reset_control_reg(reset_control_reg),
  .deep_sleep_wake_source_reg(deep_sleep_wake_source_reg),
  .deep_sleep_semaphore_regs(deep_sleep_semaphore_regs)
);

/* File: dsw_top_tb.sv */
// self-checking bench for dsw_top: rows of sleep cycles, then hand tests
// assumes dsw_top and the bound checker are compiled first
`timescale 1ns/1ps

module dsw_top_tb;
  typedef struct packed {
    logic [7:0] c;
    logic [1:0] how;
    logic       late;
    logic [2:0] src;
  } dsw_row_t;

  logic        clk = 0, sys_rst = 1, master_clear = 0, ent = 0, ext = 0, owr = 0, rel = 0;
  logic        sclr = 0, swr = 0, ssel = 0, sck = 0, lck = 0, srdy = 1, lrdy = 1;
  logic        son = 0;
  logic [7:0]  cfg = 8'h00;
  logic [15:0] rtc = 16'h0800, odat = 16'h0002, sdat = 16'h0000;
  logic        in_ds, hold, iorst, wake, srun, lrun, tick;
  logic [15:0] osc_r, reset_control_reg_r, deep_sleep_control_reg_r;
  logic [2:0]  src_r;
  logic [31:0] sem_r;
  int          failures = 0, n_tests = 0, ns = 0, nl = 0, nw = 0;
  int          nt = 0, t1 = 0, t2 = 0, t3 = 0, d = 0;
  dsw_row_t    rows [6] = '{'{8'h80, 2'h0, 1'b0, 3'h2}, '{8'h82, 2'h0, 1'b0, 3'h2},
                            '{8'hA1, 2'h0, 1'b0, 3'h2}, '{8'h80, 2'h0, 1'b1, 3'h2},
                            '{8'h00, 2'h1, 1'b0, 3'h1}, '{8'h00, 2'h2, 1'b0, 3'h4}};

  dsw_top #(.CNT_W(37)) dut (
    .clk(clk), .sys_rst(sys_rst), .master_clear_pin(master_clear), .sleep_enter(ent),
    .ext_wake_pin(ext), .config_word_four(cfg), .rtc_power_control_reg(rtc),
    .osc_wr(owr), .osc_wdata(odat), .hold_release(rel), .status_clear(sclr),
    .sem_wr(swr), .sem_sel(ssel), .sem_wdata(sdat), .secondary_oscillator_clk_pin(sck),
    .low_power_rc_clock_clk_pin(lck), .secondary_oscillator_ready_pin(srdy), .low_power_rc_clock_ready_pin(lrdy),
    .in_deep_sleep(in_ds), .io_hold(hold), .io_reset(iorst), .wake_event(wake),
    .secondary_oscillator_run(srun), .low_power_rc_clock_run(lrun), .rtc_tick(tick), .oscillator_control_reg(osc_r),
    .reset_control_reg(reset_control_reg_r), .deep_sleep_control_reg(deep_sleep_control_reg_r),
    .deep_sleep_wake_source_reg(src_r), .deep_sleep_semaphore_regs(sem_r)
  );

  initial forever #2 clk = ~clk;
  initial forever #20 sck = ~sck;
  initial forever #28 lck = ~lck;
  always @(posedge sck) ns++;
  always @(posedge lck) nl++;
  always @(posedge clk) if (wake === 1'b1) nw++;
  always @(posedge clk) if (tick === 1'b1) nt++;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  // one deep-sleep pass, woken by watchdog (0), ext pin (1) or master clear (2)
  task automatic nap(input logic [7:0] c, input int how, input bit late, input logic [2:0] src);
    int t0, w0, i, e;
    cfg = c;
    srdy = !late;
    // let the ready level pass the synchroniser before entry
    repeat (3) @(negedge clk);
    ent = 1;
    @(negedge clk) ent = 0;
    w0 = nw;
    e = 32 << c[4:0];
    chk("entry", 5'h1F, {in_ds, hold, reset_control_reg_r[10], deep_sleep_control_reg_r[1:0]});
    chk("clk_req", {c[7] & c[5], (c[7] & !c[5]) | son}, {lrun, srun});
    if (late || how != 0) repeat (400) @(negedge clk);
    chk("early_wake", 0, nw - w0);
    srdy = 1;
    ext = (how == 1);
    master_clear = (how == 2);
    t0 = c[5] ? nl : ns;
    for (i = 0; i < 5000 && wake !== 1'b1; i++) @(negedge clk);
    t0 = (c[5] ? nl : ns) - t0;
    chk("src", src, src_r);
    chk("io_reset", how == 2, iorst);
    chk("hold_kept", 2'h1, {in_ds, hold});
    if (how == 0) chk("ticks", 1, t0 >= e - 1 && t0 <= e + 1);
    ext = 0;
    master_clear = 0;
  endtask : nap

  task automatic free;
    repeat (4) @(negedge clk);
    rel = 1;
    sclr = 1;
    @(negedge clk) rel = 0;
    sclr = 0;
    chk("released", 2'h0, {hold, reset_control_reg_r[10]});
  endtask : free

  initial begin
    #200000;
    failures++;
    stop_test();
  end

  initial begin
    repeat (8) @(negedge clk);
    sys_rst = 0;
    repeat (3) @(negedge clk);
    chk("por_out", 0, {src_r, hold, iorst, wake, in_ds, reset_control_reg_r[10], osc_r[1]});
    foreach (rows[k]) begin
      nap(rows[k].c, rows[k].how, rows[k].late, rows[k].src);
      free();
    end
    for (int s = 0; s < 4; s++) begin
      rtc[11:10] = s[1:0];
      @(negedge clk);
      chk("rtc_sel", {s == 1, s == 0}, {lrun, srun});
      t1 = nt;
      t2 = ns;
      t3 = nl;
      repeat (140) @(negedge clk);
      d = (nt - t1) - (s == 0 ? ns - t2 : s == 1 ? nl - t3 : 0);
      chk("rtc_ticks", 1, d >= -1 && d <= 1);
    end
    rtc = 16'h0800;
    swr = 1;
    sdat = 16'hA5A5;
    @(negedge clk) ssel = 1;
    sdat = 16'h5A5A;
    @(negedge clk) swr = 0;
    chk("sem", 32'h5A5AA5A5, sem_r);
    nap(8'h00, 1, 0, 3'h1);
    owr = 1;
    @(negedge clk) owr = 0;
    chk("osc_locked", 0, osc_r);
    free();
    owr = 1;
    @(negedge clk) owr = 0;
    son = 1;
    chk("osc_set", 16'h0002, osc_r);
    nap(8'h85, 2, 0, 3'h4);
    chk("osc_kept", 16'h0002, osc_r);
    chk("sem_kept", 32'h5A5AA5A5, sem_r);
    chk("ctrl_hold", 1, deep_sleep_control_reg_r[0]);
    // master clear while awake: pins, hold, oscillator and source cleared
    repeat (4) @(negedge clk);
    master_clear = 1;
    for (int i = 0; i < 8 && iorst !== 1'b1; i++) @(negedge clk);
    master_clear = 0;
    chk("master_clear_awake", 5'h10, {iorst, wake, hold, osc_r[1], in_ds});
    chk("master_clear_src", 0, src_r);
    chk("sem_master_clear", 32'h5A5AA5A5, sem_r);
    sys_rst = 1;
    repeat (3) @(negedge clk);
    sys_rst = 0;
    chk("por_sem", 0, sem_r);
    chk("por_state", 0, {osc_r[1], hold, reset_control_reg_r[10], src_r, deep_sleep_control_reg_r[0]});
    stop_test();
  end
endmodule : dsw_top_tb
